// ---- design/ircs_pkg.sv ----
/*
 ircs_pkg: constants and types of the idle/run power mode clock switch.
 assumes a single 100 MHz system clock and a 4-bit Avalon-MM byte address.
*/
package ircs_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int CLK_PERIOD_NS = 10;
   localparam int WAKE_DLY_NS = 10000;
   localparam int WAKE_CYC = (WAKE_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INT_STAB_US = 1000;
   localparam int INT_STAB_CYC = INT_STAB_US * CLK_MHZ;
   localparam int WAKE_CNT_W = 10;
   localparam int STAB_W = 17;
   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_TCTRL = 4'h4;
   localparam logic [3:0] ADDR_CFG = 4'h8;
   localparam logic [3:0] ADDR_STAT = 4'hc;
   localparam int IDLE_BIT = 7;
   localparam int FREQ_LSB = 4;
   localparam int PRIRDY_BIT = 3;
   localparam int INTSTB_BIT = 2;
   localparam int CSS_LSB = 0;
   localparam int SECRUN_BIT = 6;
   localparam int SECEN_BIT = 3;
   localparam int WDTEN_BIT = 0;
   localparam int FSCM_BIT = 1;
   localparam int INTPRI_BIT = 2;
   localparam int EXIT_BIT = 4;
   localparam int DLY_BIT = 3;
   localparam int ST_LSB = 0;
   // ----------------------------------------
   // encodings
   // ----------------------------------------
   localparam logic [1:0] CSS_SEC = 2'h1;
   localparam int CSS_RC_BIT = 1;
   typedef logic [1:0] ircs_clksel_t;
   localparam ircs_clksel_t CLK_PRI = 2'h0;
   localparam ircs_clksel_t CLK_SEC = 2'h1;
   localparam ircs_clksel_t CLK_INT = 2'h2;
   localparam ircs_clksel_t CLK_NONE = 2'h3;
   typedef enum logic [2:0] {
      ST_PRIRUN = 3'h0,
      ST_PRIIDLE = 3'h1,
      ST_SECIDLE = 3'h3,
      ST_SECRUN = 3'h2,
      ST_RCRUN = 3'h6,
      ST_RCIDLE = 3'h7,
      ST_SLEEP = 3'h5
   } ircs_state_e;
endpackage

// ---- design/ircs_power_mode.sv ----
/*
 ircs_power_mode: selects run, idle and sleep modes at the sleep instruction,
 gates cpu and peripheral clocks and switches the system clock source.
 assumes oscillator-ready inputs synchronous to mclk and one-cycle event pulses.
*/
`timescale 1ns/1ps
module ircs_power_mode
   import ircs_pkg::*;
#(
   parameter int INT_STAB_CYC_P = ircs_pkg::INT_STAB_CYC
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // avalon-mm slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // cpu events
   input wire logic sleepExec,
   input wire logic resetInstr,
   input wire logic wakeIrq,
   input wire logic wdtTimeout,
   // oscillator status
   input wire logic priClkReady,
   input wire logic secOscRunning,
   // clock control
   output logic cpuClkEn,
   output logic periClkEn,
   output ircs_pkg::ircs_clksel_t sysClkSel,
   output logic priOscEn,
   output logic intOscEn,
   output logic intRcEn,
   output logic secOscOn,
   output logic wdtRstReq,
   // source flags
   output logic primaryReadyFlag,
   output logic internalStableFlag,
   output logic secondaryRunningFlag
);
   import ircs_pkg::*;

   // ----------------------------------------
   // decoding helpers
   // ----------------------------------------
   function automatic logic isSec(input ircs_state_e s);
      return (s == ST_SECRUN) || (s == ST_SECIDLE);
   endfunction
   function automatic logic isRc(input ircs_state_e s);
      return (s == ST_RCRUN) || (s == ST_RCIDLE);
   endfunction
   function automatic logic isPri(input ircs_state_e s);
      return (s == ST_PRIRUN) || (s == ST_PRIIDLE);
   endfunction
   function automatic logic isRun(input ircs_state_e s);
      return (s == ST_PRIRUN) || (s == ST_SECRUN) || (s == ST_RCRUN);
   endfunction
   function automatic logic isIdle(input ircs_state_e s);
      return (s == ST_PRIIDLE) || (s == ST_SECIDLE) || (s == ST_RCIDLE);
   endfunction
   function automatic ircs_state_e runOf(input ircs_state_e s);
      return isSec(s) ? ST_SECRUN : (isRc(s) ? ST_RCRUN : ST_PRIRUN);
   endfunction

   // ----------------------------------------
   // state and registers
   // ----------------------------------------
   ircs_state_e st_r, stNxt;
   logic dly_r, dlyNxt, exit_r, exitNxt, wdtRstNxt, ack_r;
   logic [WAKE_CNT_W-1:0] cnt_r, cntNxt;
   logic [STAB_W-1:0] stab_r;
   logic idleEn_r, secEn_r, wdtEn_r, fscmEn_r, intPri_r;
   logic [1:0] css_r;
   logic [2:0] freq_r;
   logic [31:0] rdMux;

   // ----------------------------------------
   // avalon slave: one wait cycle per access
   // ----------------------------------------
   wire req = read | write;
   wire wrEn = write & ack_r;
   wire wrCtrl = wrEn & (address == ADDR_CTRL);
   wire wrTctrl = wrEn & (address == ADDR_TCTRL);
   wire wrCfg = wrEn & (address == ADDR_CFG);
   assign waitrequest = req & ~ack_r;

   always_comb
   begin
      rdMux = 32'h0;
      case (address)
         ADDR_CTRL:
         begin
            rdMux[IDLE_BIT] = idleEn_r;
            rdMux[FREQ_LSB +: 3] = freq_r;
            rdMux[PRIRDY_BIT] = primaryReadyFlag;
            rdMux[INTSTB_BIT] = internalStableFlag;
            rdMux[CSS_LSB +: 2] = css_r;
         end
         ADDR_TCTRL:
         begin
            rdMux[SECRUN_BIT] = secondaryRunningFlag;
            rdMux[SECEN_BIT] = secEn_r;
         end
         ADDR_CFG:
         begin
            rdMux[WDTEN_BIT] = wdtEn_r;
            rdMux[FSCM_BIT] = fscmEn_r;
            rdMux[INTPRI_BIT] = intPri_r;
         end
         ADDR_STAT:
         begin
            rdMux[EXIT_BIT] = exit_r;
            rdMux[DLY_BIT] = dly_r;
            rdMux[ST_LSB +: 3] = st_r;
         end
         default: rdMux = 32'h0;
      endcase
   end

   // only software writes touch the select bits; wake-up leaves them alone
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         ack_r <= 1'b0;
         readdata <= 32'h0;
         idleEn_r <= 1'b0;
         css_r <= 2'h0;
         freq_r <= 3'h0;
         secEn_r <= 1'b0;
         wdtEn_r <= 1'b0;
         fscmEn_r <= 1'b0;
         intPri_r <= 1'b0;
      end
      else
      begin
         ack_r <= req & ~ack_r;
         if (read & ~ack_r)
         begin
            readdata <= rdMux;
         end
         if (wrCtrl)
         begin
            idleEn_r <= writedata[IDLE_BIT];
            css_r <= writedata[CSS_LSB +: 2];
            freq_r <= writedata[FREQ_LSB +: 3];
         end
         if (wrTctrl)
         begin
            secEn_r <= writedata[SECEN_BIT];
         end
         if (wrCfg)
         begin
            wdtEn_r <= writedata[WDTEN_BIT];
            fscmEn_r <= writedata[FSCM_BIT];
            intPri_r <= writedata[INTPRI_BIT];
         end
      end
   end

   // ----------------------------------------
   // mode selection at the sleep instruction
   // ----------------------------------------
   wire sleepIgnored = (css_r == CSS_SEC) & ~secEn_r;
   wire wakeEvt = wakeIrq | wdtTimeout;
   wire cntDone = (cnt_r == WAKE_CNT_W'(0));
   ircs_state_e sleepTarget;
   assign sleepTarget = css_r[CSS_RC_BIT] ? (idleEn_r ? ST_RCIDLE : ST_RCRUN)
      : (css_r == CSS_SEC) ? (idleEn_r ? ST_SECIDLE : ST_SECRUN)
      : (idleEn_r ? ST_PRIIDLE : ST_SLEEP);

   always_comb
   begin
      stNxt = st_r;
      dlyNxt = dly_r;
      exitNxt = exit_r;
      cntNxt = dly_r ? cnt_r - WAKE_CNT_W'(1) : cnt_r;
      wdtRstNxt = 1'b0;
      case (st_r)
         ST_PRIRUN, ST_SECRUN, ST_RCRUN:
         begin
            if (wdtTimeout || resetInstr)
            begin
               stNxt = ST_PRIRUN;
               exitNxt = 1'b0;
               wdtRstNxt = 1'b1;
            end
            else if (sleepExec && !sleepIgnored)
            begin
               stNxt = sleepTarget;
               exitNxt = 1'b0;
            end
            else if (st_r != ST_PRIRUN)
            begin
               if (exit_r && priClkReady)
               begin
                  stNxt = ST_PRIRUN;
                  exitNxt = 1'b0;
               end
               else if (wakeIrq || (isSec(st_r) && !secEn_r))
               begin
                  exitNxt = 1'b1;
               end
            end
         end
         ST_PRIIDLE, ST_SECIDLE, ST_RCIDLE:
         begin
            if (dly_r)
            begin
               if (cntDone)
               begin
                  dlyNxt = 1'b0;
                  stNxt = runOf(st_r);
                  exitNxt = (st_r != ST_PRIIDLE);
               end
            end
            else if (wakeEvt)
            begin
               dlyNxt = 1'b1;
               cntNxt = WAKE_CNT_W'(WAKE_CYC - 1);
            end
         end
         ST_SLEEP:
         begin
            if (wakeEvt)
            begin
               dlyNxt = 1'b1;
            end
            if (dly_r && priClkReady)
            begin
               stNxt = ST_PRIRUN;
               dlyNxt = 1'b0;
            end
         end
         default: stNxt = ST_PRIRUN;
      endcase
   end

   // ----------------------------------------
   // clock gating and source outputs
   // ----------------------------------------
   // outputs are derived from the next state so they change together with it
   wire secNxt = isSec(stNxt);
   wire rcNxt = isRc(stNxt);
   wire priNxt = isPri(stNxt);
   wire freqNz = |freq_r;
   wire stable = (stab_r == STAB_W'(INT_STAB_CYC_P));
   wire secGate = ~secNxt | secOscRunning;
   wire cpuClkEn_nxt = isRun(stNxt) & secGate;
   wire periClkEn_nxt = (stNxt != ST_SLEEP) & secGate;
   wire priOscEn_nxt = priNxt | exitNxt | dlyNxt;
   wire intOscEn_nxt = freqNz & (rcNxt | (priNxt & intPri_r));
   wire intRcEn_nxt = (rcNxt & ~freqNz) | wdtEn_r | fscmEn_r;
   wire secOscOn_nxt = secEn_r | secNxt;
   wire priRdy_nxt = priNxt;
   wire intStb_nxt = stable & freqNz & (rcNxt | ((stNxt == ST_PRIRUN) & intPri_r));
   ircs_clksel_t sysClkSel_nxt;
   assign sysClkSel_nxt = priNxt ? CLK_PRI : secNxt ? CLK_SEC : rcNxt ? CLK_INT : CLK_NONE;

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         st_r <= ST_PRIRUN;
         dly_r <= 1'b0;
         exit_r <= 1'b0;
         cnt_r <= '0;
         cpuClkEn <= 1'b1;
         periClkEn <= 1'b1;
         sysClkSel <= CLK_PRI;
         priOscEn <= 1'b1;
         intOscEn <= 1'b0;
         intRcEn <= 1'b0;
         secOscOn <= 1'b0;
         wdtRstReq <= 1'b0;
         primaryReadyFlag <= 1'b1;
         internalStableFlag <= 1'b0;
         secondaryRunningFlag <= 1'b0;
      end
      else
      begin
         st_r <= stNxt;
         dly_r <= dlyNxt;
         exit_r <= exitNxt;
         cnt_r <= cntNxt;
         cpuClkEn <= cpuClkEn_nxt;
         periClkEn <= periClkEn_nxt;
         sysClkSel <= sysClkSel_nxt;
         priOscEn <= priOscEn_nxt;
         intOscEn <= intOscEn_nxt;
         intRcEn <= intRcEn_nxt;
         secOscOn <= secOscOn_nxt;
         wdtRstReq <= wdtRstNxt;
         primaryReadyFlag <= priRdy_nxt;
         internalStableFlag <= intStb_nxt;
         secondaryRunningFlag <= secNxt;
      end
   end

   // stability is counted only while the fast oscillator actually runs
   always_ff @(posedge mclk)
   begin
      if (sys_rst || !intOscEn)
      begin
         stab_r <= '0;
      end
      else if (!stable)
      begin
         stab_r <= stab_r + STAB_W'(1);
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   int dlyLen;
   always_ff @(posedge mclk)
   begin
      if (sys_rst || !dly_r)
      begin
         dlyLen <= 0;
      end
      else
      begin
         dlyLen <= dlyLen + 1;
      end
   end

   idle_cpu_off_a: assert property (@(posedge mclk) disable iff (sys_rst)
      isIdle(st_r) |-> !cpuClkEn && periClkEn == (!isSec(st_r) || $past(secOscRunning)))
      else $error("cpu clocked in idle mode");
   wake_delay_a: assert property (@(posedge mclk) disable iff (sys_rst)
      $fell(dly_r) && $past(st_r) != ST_SLEEP |-> dlyLen == WAKE_CYC && cpuClkEn)
      else $error("wake delay length wrong");
   sec_ignore_a: assert property (@(posedge mclk) disable iff (sys_rst)
      isRun(st_r) && sleepExec && css_r == CSS_SEC && !secEn_r && !wdtTimeout && !resetInstr
      && !(exit_r && priClkReady) |=> st_r == $past(st_r))
      else $error("sleep not ignored without secondary enable");
   flag_onehot_a: assert property (@(posedge mclk) disable iff (sys_rst)
      st_r != ST_PRIRUN |-> $onehot0({primaryReadyFlag, internalStableFlag,
      secondaryRunningFlag}))
      else $error("more than one source flag set");
   switch_ready_a: assert property (@(posedge mclk) disable iff (sys_rst)
      sysClkSel == CLK_PRI && $past(sysClkSel) != CLK_PRI
      |-> $past(priClkReady) || $past(wdtTimeout) || $past(resetInstr))
      else $error("switch to primary before ready");
   sec_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
      isSec(st_r) && !$past(secOscRunning) |-> !periClkEn && !cpuClkEn)
      else $error("clocks given before secondary runs");
   wdt_reset_a: assert property (@(posedge mclk) disable iff (sys_rst)
      isRun(st_r) && wdtTimeout |=> wdtRstReq && st_r == ST_PRIRUN && primaryReadyFlag)
      else $error("watchdog in run mode without reset");
   sec_keep_a: assert property (@(posedge mclk) disable iff (sys_rst)
      st_r == ST_SECRUN && !secEn_r |-> secOscOn ##1 (secOscOn || st_r != ST_SECRUN))
      else $error("secondary stopped before switchback");
   ctrl_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !wrCtrl |=> $stable(idleEn_r) && $stable(css_r))
      else $error("select bits changed without a write");
   internal_slow_rc_keep_a: assert property (@(posedge mclk) disable iff (sys_rst)
      wdtEn_r || fscmEn_r |=> intRcEn)
      else $error("slow rc stopped while needed");
   zero_freq_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !freqNz [*2] |-> !internalStableFlag && !intOscEn)
      else $error("internal flag with zero frequency select");
endmodule

// ---- test/test_idle_run_power_mode_clock_switch.sv ----
/*
 test_idle_run_power_mode_clock_switch: self-checking bench for ircs_power_mode.
 assumes the 100 MHz mclk, synchronous sys_rst and the one-wait-state avalon slave.
*/
`timescale 1ns/1ps
module test_idle_run_power_mode_clock_switch;
   import ircs_pkg::*;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [3:0] address = 4'h0;
   logic [31:0] writedata = 32'h0;
   logic [3:0] ev = 4'h0;
   logic priClkReady = 1'b1;
   logic secOscRunning = 1'b1;
   logic [31:0] readdata;
   logic [31:0] rdv;
   logic waitrequest;
   logic cpuClkEn;
   logic periClkEn;
   ircs_clksel_t sysClkSel;
   logic priOscEn;
   logic intOscEn;
   logic intRcEn;
   logic secOscOn;
   logic wdtRstReq;
   logic primaryReadyFlag;
   logic internalStableFlag;
   logic secondaryRunningFlag;
   int errors = 0;
   int total_checks = 0;
   int n;
   wire [7:0] outs = {cpuClkEn, periClkEn, sysClkSel, priOscEn, primaryReadyFlag,
      internalStableFlag, secondaryRunningFlag};
   wire [2:0] flags = {internalStableFlag, primaryReadyFlag, cpuClkEn};

   // short stability count keeps the run small
   ircs_power_mode #(.INT_STAB_CYC_P(20)) DUT (.mclk(mclk), .sys_rst(sys_rst),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .sleepExec(ev[0]),
      .resetInstr(ev[1]), .wakeIrq(ev[2]), .wdtTimeout(ev[3]),
      .priClkReady(priClkReady), .secOscRunning(secOscRunning), .cpuClkEn(cpuClkEn),
      .periClkEn(periClkEn), .sysClkSel(sysClkSel), .priOscEn(priOscEn),
      .intOscEn(intOscEn), .intRcEn(intRcEn), .secOscOn(secOscOn),
      .wdtRstReq(wdtRstReq), .primaryReadyFlag(primaryReadyFlag),
      .internalStableFlag(internalStableFlag),
      .secondaryRunningFlag(secondaryRunningFlag));

   initial
   begin
      forever #5 mclk = ~mclk;
   end

   // ----------------------------------------
   // expectations and helpers
   // ----------------------------------------
   // clock outputs for a state code: cpu, peri, select, pri osc, three flags
   function automatic logic [7:0] mexp(logic [2:0] s, logic po, logic is);
      logic [1:0] sel;
      sel = s[2] ? 2'h2 : {1'b0, s[1]};
      return {!s[0], 1'b1, sel, (s <= 3'h1) | po, s <= 3'h1, is, sel == 2'h1};
   endfunction

   task results();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task co(input logic [7:0] e);
      chk("clock outputs", {24'h0, e}, {24'h0, outs});
   endtask

   // holds the request until waitrequest is sampled low at a rising edge
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      logic low;
      int k;
      k = 0;
      low = 1'b0;
      @(posedge mclk);
      address <= a;
      writedata <= d;
      write <= w;
      read <= !w;
      do
      begin
         @(posedge mclk);
         k++;
         low = (waitrequest === 1'b0);
      end
      while (!low && k < 20);
      // read data is taken at the very edge that ends the wait
      rdv = readdata;
      write <= 1'b0;
      read <= 1'b0;
      if (!low)
      begin
         errors++;
         $display("[FAIL] bus answer expected 0 seen 1");
         results();
      end
   endtask

   task pulse(input int i);
      @(posedge mclk);
      ev[i] <= 1'b1;
      @(posedge mclk);
      ev[i] <= 1'b0;
      #1;
   endtask

   // a wait that runs out ends the run as a mismatch
   task wt(input int s, input int lim);
      n = 0;
      while (flags[s] !== 1'b1 && n < lim)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n >= lim)
      begin
         errors++;
         $display("[FAIL] wait %0d expected 1 seen 0", s);
         results();
      end
   endtask

   task back();
      @(posedge mclk);
      priClkReady <= 1'b1;
      wt(1, 8);
      co(mexp(3'h0, 1'b0, 1'b0));
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      int k;
      int f;
      int idl;
      int clock_source_select_bits;
      int cfg;
      logic [2:0] st;
      void'($urandom(63382));
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      #1;
      co(mexp(3'h0, 1'b0, 1'b0));
      bus(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl", 32'h08, rdv);
      bus(1'b0, 4'h2, 32'h0);
      chk("unmapped", 32'h0, rdv);
      $display("test reset done");
      // idle on primary, woken by interrupt then by watchdog
      for (k = 0; k < 2; k++)
      begin
         bus(1'b1, ADDR_CTRL, 32'h80);
         pulse(0);
         co(mexp(3'h1, 1'b0, 1'b0));
         pulse(k == 0 ? 2 : 3);
         chk("reset request", 32'h0, {31'h0, wdtRstReq});
         wt(0, 1100);
         chk("wake delay", 32'd1000, n);
         co(mexp(3'h0, 1'b0, 1'b0));
         bus(1'b0, ADDR_CTRL, 32'h0);
         chk("ctrl", 32'h88, rdv);
      end
      $display("test primary idle done");
      bus(1'b1, ADDR_TCTRL, 32'h0);
      bus(1'b1, ADDR_CTRL, 32'h01);
      pulse(0);
      co(mexp(3'h0, 1'b0, 1'b0));
      bus(1'b0, ADDR_STAT, 32'h0);
      chk("state", 32'h0, rdv);
      $display("test refused sleep done");
      // secondary idle with the oscillator not yet oscillating
      secOscRunning <= 1'b0;
      bus(1'b1, ADDR_TCTRL, 32'h08);
      bus(1'b1, ADDR_CTRL, 32'h81);
      priClkReady <= 1'b0;
      pulse(0);
      co(mexp(3'h3, 1'b0, 1'b0) & 8'hbf);
      @(posedge mclk);
      secOscRunning <= 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      co(mexp(3'h3, 1'b0, 1'b0));
      pulse(2);
      co(mexp(3'h3, 1'b1, 1'b0));
      wt(0, 1100);
      chk("wake delay", 32'd1000, n);
      co(mexp(3'h2, 1'b1, 1'b0));
      back();
      chk("secondary on", 32'h1, {31'h0, secOscOn});
      $display("test secondary idle done");
      bus(1'b1, ADDR_CTRL, 32'h01);
      priClkReady <= 1'b0;
      pulse(0);
      co(mexp(3'h2, 1'b0, 1'b0));
      bus(1'b0, ADDR_TCTRL, 32'h0);
      chk("tctrl", 32'h48, rdv);
      pulse(2);
      repeat (2) @(posedge mclk);
      #1;
      co(mexp(3'h2, 1'b1, 1'b0));
      back();
      chk("secondary on", 32'h1, {31'h0, secOscOn});
      $display("test secondary run done");
      @(posedge mclk);
      priClkReady <= 1'b0;
      pulse(0);
      bus(1'b1, ADDR_TCTRL, 32'h0);
      repeat (2) @(posedge mclk);
      #1;
      co(mexp(3'h2, 1'b1, 1'b0));
      chk("secondary on", 32'h1, {31'h0, secOscOn});
      back();
      chk("secondary on", 32'h0, {31'h0, secOscOn});
      $display("test secondary exit done");
      // watchdog and reset instruction in a run mode
      for (k = 1; k < 4; k += 2)
      begin
         bus(1'b1, ADDR_TCTRL, 32'h08);
         bus(1'b1, ADDR_CTRL, 32'h01);
         priClkReady <= 1'b0;
         pulse(0);
         pulse(k);
         chk("reset request", 32'h1, {31'h0, wdtRstReq});
         co(mexp(3'h0, 1'b0, 1'b0));
         @(posedge mclk);
         priClkReady <= 1'b1;
      end
      $display("test run reset done");
      // full sleep: every clock gated and no source selected until primary is back
      bus(1'b1, ADDR_CTRL, 32'h0);
      priClkReady <= 1'b0;
      pulse(0);
      co(8'h30);
      pulse(3);
      chk("reset request", 32'h0, {31'h0, wdtRstReq});
      co(8'h38);
      back();
      $display("test sleep done");
      // internal oscillator modes, random settings, first with zero frequency
      for (k = 0; k < 6; k++)
      begin
         f = (k == 0) ? 0 : $urandom_range(7, 1);
         idl = $urandom_range(1, 0);
         clock_source_select_bits = 2 | $urandom_range(1, 0);
         cfg = $urandom_range(3, 0);
         st = idl ? 3'h7 : 3'h6;
         bus(1'b1, ADDR_CFG, cfg);
         bus(1'b1, ADDR_CTRL, {24'h0, idl[0], f[2:0], 2'h0, clock_source_select_bits[1:0]});
         priClkReady <= 1'b0;
         pulse(0);
         co(mexp(st, 1'b0, 1'b0));
         chk("fast osc on", f != 0, {31'h0, intOscEn});
         if (f != 0)
         begin
            wt(2, 40);
            co(mexp(st, 1'b0, 1'b1));
         end
         else
         begin
            repeat (40) @(posedge mclk);
            #1;
            co(mexp(st, 1'b0, 1'b0));
         end
         pulse(2);
         if (idl)
         begin
            wt(0, 1100);
            chk("wake delay", 32'd1000, n);
         end
         repeat (2) @(posedge mclk);
         #1;
         co(mexp(3'h6, 1'b1, f != 0));
         back();
         chk("slow rc on", cfg != 0, {31'h0, intRcEn});
         bus(1'b0, ADDR_CTRL, 32'h0);
         chk("ctrl", {24'h0, idl[0], f[2:0], 2'h2, clock_source_select_bits[1:0]}, rdv);
      end
      $display("test internal modes done");
      results();
   end
endmodule
